// ### pkg/pm_cfg_consts.svh
// Offsets, field positions, reset values and timing counts of the config header tail
`ifndef PM_CFG_CONSTS_SVH
`define PM_CFG_CONSTS_SVH

`define OFF_SUBSYS 8'h2C
`define OFF_CAP_PTR 8'h34
`define OFF_INT_WORD 8'h3C
`define OFF_PM_CAP 8'h40
`define OFF_PM_CTRL 8'h44
`define PM_RANGE_LO 8'h40
`define PM_RANGE_HI 8'h47

`define CAP_PTR_VAL 8'h40
`define INT_PIN_VAL 8'h01
`define INT_LINE_RST 8'h00
`define AUX_CUR_VAL 3'h1
`define PM_REV_VAL 3'h2
`define CAP_ID_VAL 8'h01

`define BIT_PRODUCT_WE 11
`define BIT_VENDOR_WE 1

`define BIT_D3COLD 31
`define BIT_D3HOT 30
`define BIT_D2WAKE 29
`define BIT_D0WAKE 27
`define BIT_D2SUP 26
`define POS_AUX_CURRENT_CODE 22
`define POS_PM_SPEC_REVISION 16

// Longest time to wait for the EEPROM answer after reset, in ns
`define EE_TIMEOUT_NS 2000
`define CLK_PERIOD_NS 10
`define EE_TIMEOUT_CYC (`EE_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

// ### pkg/pm_cfg_pkg.sv
// Types shared by the configuration header tail
package pm_cfg_pkg;

  // Load sequencer states, Gray along PROBE-WAIT-DONE; the direct PROBE to DONE step flips both bits
  typedef enum logic [1:0] {
    ST_PROBE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } load_state_t;

  // Configuration access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  // Identity pair from EEPROM or firmware
  typedef struct packed {
    logic [15:0] product;
    logic [15:0] vendor;
  } ident_t;

  // All state of the block except the two reset-release flops
  typedef struct packed {
    load_state_t st;
    logic [7:0] tmo;
    ident_t ident;
    logic [7:0] int_line;
    logic [31:0] rdata;
    logic hit;
    logic ee_req;
    logic aux_m;
    logic aux_s;
  } state_t;

endpackage

// ### rtl/pm_cfg_regs.sv
// Subsystem identity, capability pointer, interrupt word and power-management capability
`timescale 1ns/1ns
`include "pm_cfg_consts.svh"
module pm_cfg_regs
  import pm_cfg_pkg::*;
#(
  parameter logic [15:0] DEF_PRODUCT = 16'h0A5A, // Arbitrary value
  parameter logic [15:0] DEF_VENDOR = 16'h0C3C // Arbitrary value
)(
  input wire logic clk, // 100 MHz configuration clock
  input wire logic rst_n, // Async active-low reset
  input wire cfg_req_t req, // Configuration access
  output logic [31:0] rdata, // Read data, registered
  output logic hit, // Access decoded by this block, registered
  input wire logic ee_present, // EEPROM probe answer
  input wire logic ee_valid, // EEPROM contents valid, one-cycle with ee_ident
  input wire ident_t ee_ident, // Identity read from EEPROM
  output logic ee_req, // Asks the EEPROM loader to run
  output logic load_done, // Identity load finished
  input wire logic [15:0] local_ctl6, // Local control register 6
  input wire ident_t fw_ident, // Firmware overwrite value
  input wire logic fw_wr, // Firmware write strobe
  input wire logic aux_power_detect // Aux power present, asynchronous pin
);

  logic rst_m_r, rst_s_r;
  state_t s_r, s_nxt;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  // Read word assembly per offset
  function automatic logic [31:0] read_word(input logic [7:0] a, input state_t s);
    logic [31:0] w;
    w = 32'h0;
    if (a == `OFF_SUBSYS)
      w = {s.ident.product, s.ident.vendor};
    else if (a == `OFF_CAP_PTR)
      w = {24'h0, `CAP_PTR_VAL};
    else if (a == `OFF_INT_WORD)
      w = {16'h0, `INT_PIN_VAL, s.int_line};
    else if (a == `OFF_PM_CAP)
    begin
      w[`BIT_D3COLD] = s.aux_s;
      w[`BIT_D3HOT] = 1'b1;
      w[`BIT_D2WAKE] = 1'b1;
      w[`BIT_D0WAKE] = 1'b1;
      w[`BIT_D2SUP] = 1'b1;
      w[`POS_AUX_CURRENT_CODE +: 3] = `AUX_CUR_VAL;
      w[`POS_PM_SPEC_REVISION +: 3] = `PM_REV_VAL;
      w[7:0] = `CAP_ID_VAL;
    end
    return w;
  endfunction

  // Offsets this block answers
  function automatic logic decoded(input logic [7:0] a);
    logic d;
    d = 1'b0;
    if (a == `OFF_SUBSYS || a == `OFF_CAP_PTR || a == `OFF_INT_WORD)
      d = 1'b1;
    else if (a >= `PM_RANGE_LO && a <= `PM_RANGE_HI)
      d = 1'b1;
    return d;
  endfunction

  // Next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.aux_m = aux_power_detect;
    s_nxt.aux_s = s_r.aux_m;
    s_nxt.ee_req = 1'b0;
    case (s_r.st)
      ST_PROBE:
      begin
        s_nxt.tmo = 8'h0;
        if (ee_present)
        begin
          s_nxt.ee_req = 1'b1;
          s_nxt.st = ST_WAIT;
        end
        else
          s_nxt.st = ST_DONE;
      end
      ST_WAIT:
      begin
        s_nxt.ee_req = 1'b1;
        s_nxt.tmo = s_r.tmo + 8'h1;
        if (ee_valid)
        begin
          s_nxt.ident = ee_ident;
          s_nxt.st = ST_DONE;
        end
        else if (s_r.tmo == 8'(`EE_TIMEOUT_CYC - 1))
          s_nxt.st = ST_DONE;
      end
      default:
        s_nxt.st = ST_DONE;
    endcase
    // Firmware overwrite under local write enables
    if (fw_wr && local_ctl6[`BIT_PRODUCT_WE])
      s_nxt.ident.product = fw_ident.product;
    if (fw_wr && local_ctl6[`BIT_VENDOR_WE])
      s_nxt.ident.vendor = fw_ident.vendor;
    // Only the interrupt line byte takes configuration writes
    if (req.wr && req.addr == `OFF_INT_WORD && req.be[0])
      s_nxt.int_line = req.wdata[7:0];
    s_nxt.hit = (req.rd || req.wr) && decoded(req.addr);
    s_nxt.rdata = req.rd ? read_word(req.addr, s_r) : 32'h0;
  end

  // State register, held in reset until the synchronised release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.st <= ST_PROBE;
      s_r.ident <= {DEF_PRODUCT, DEF_VENDOR};
      s_r.int_line <= `INT_LINE_RST;
    end
    else if (!rst_s_r)
    begin
      s_r <= '0;
      s_r.st <= ST_PROBE;
      s_r.ident <= {DEF_PRODUCT, DEF_VENDOR};
      s_r.int_line <= `INT_LINE_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign rdata = s_r.rdata;
  assign hit = s_r.hit;
  assign ee_req = s_r.ee_req;
  assign load_done = (s_r.st == ST_DONE);

endmodule // pm_cfg_regs

// ### verification/pm_cfg_regs_monitor.sv
// Assertions on the config header tail
`timescale 1ns/1ns
module pm_mon
  import pm_cfg_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire cfg_req_t req, // Access
  input wire logic [31:0] rdata, // Data
  input wire logic hit, // Decode
  input wire logic aux_power_detect // Aux pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Decoded access
  wire r = req.rd;
  wire a = req.rd | req.wr;
  wire [7:0] ad = req.addr;
  wire pm = ad inside {[8'h40:8'h47]};
  wire mp = pm || ad inside {8'h2C, 8'h34, 8'h3C};
  // Read values and decode
  ptr_read_a: assert property (r && ad == 8'h34 |=> rdata == 32'h40) else $error("ptr");
  pin_read_a: assert property (r && ad == 8'h3C |=> rdata[31:8] == 24'h1) else $error("pin");
  cap_word_a: assert property (r && ad == 8'h40 |=> rdata[30:0] == 31'h6C420001) else $error("cap");
  cold_wake_a: assert property ($stable(aux_power_detect)[*5] ##0 r && ad == 8'h40
    |=> rdata[31] == aux_power_detect) else $error("d3c");
  pm_range_a: assert property (a && pm |=> hit) else $error("range");
  no_decode_a: assert property (a && !mp |=> !hit && rdata == 32'h0) else $error("unmapped");
  ident_hit_a: assert property (a && ad == 8'h2C |=> hit) else $error("ident");
  line_store_a: assert property (req.wr && ad == 8'h3C && req.be[0] ##2 r && ad == 8'h3C
    |=> rdata[7:0] == $past(req.wdata[7:0], 3)) else $error("line");
  cover property (r && ad == 8'h40 ##1 rdata[31]);
  cover property (req.wr && ad == 8'h3C);
  cover property (a && !mp);
endmodule // pm_mon

bind pm_cfg_regs pm_mon i_mon (.*);

// ### verification/ee_model.sv
// Serial EEPROM loader stand-in
`timescale 1ns/1ns
module ee_model
  import pm_cfg_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic ee_req, // Request
  input wire logic ee_present, // Fitted
  output logic ee_valid, // Strobe
  output ident_t ee_ident // Identity
);
  initial ee_ident = 32'h0;
  // Strobe in every other cycle while ee_present and ee_req are high, data scrambled outside the strobes
  always @(posedge clk)
  begin
    ee_valid <= ee_present && ee_req && !ee_valid;
    ee_ident <= (ee_present && ee_req && !ee_valid) ? 32'h5A5AA5A5 : ~ee_ident;
  end
endmodule // ee_model

// ### verification/test_pci_config_header_pm_capability.sv
// Bench for the config header tail
`timescale 1ns/1ns
module test_pci_config_header_pm_capability;
  import pm_cfg_pkg::*;
  logic clk, rst_n, aux_power_detect, ee_present, fw_wr, hit, ee_valid, ee_req, load_done;
  logic [31:0] rdata;
  logic [15:0] local_ctl6;
  cfg_req_t req;
  ident_t ee_ident, fw_ident;
  int mismatches, tests_run;
  pm_cfg_regs i_dut (.*);
  ee_model i_ee (.*);
  // Clock
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Verdict
  task complete_run;
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One access; the answer stands for the cycle right after the taking edge
  task acc(input logic w, input logic [7:0] ad, input logic [3:0] be, input logic [31:0] d, input logic [32:0] e);
    req = '{~w, w, ad, be, d};
    @(negedge clk);
    tests_run++;
    if ({hit, rdata} !== e)
    begin
      $display("BAD %0t %h %h", $time, {hit, rdata}, e);
      mismatches++;
    end
    req = '0;
    @(negedge clk);
  endtask
  // Firmware overwrite strobe
  task fw(input logic [15:0] c, input ident_t v);
    local_ctl6 = c;
    fw_ident = v;
    fw_wr = 1;
    @(negedge clk);
    fw_wr = 0;
    @(negedge clk);
  endtask
  // Reset, then bounded wait for the identity load
  task boot(input logic f);
    ee_present = f;
    rst_n = 0;
    repeat (6) @(negedge clk);
    rst_n = 1;
    for (int i = 0; i < 400 && load_done !== 1'b1; i++)
      @(negedge clk);
    if (load_done !== 1'b1)
    begin
      mismatches++;
      complete_run;
    end
  endtask
  // Scenarios
  initial
  begin
    mismatches = 0;
    tests_run = 0;
    aux_power_detect = 0;
    local_ctl6 = 16'h0;
    fw_wr = 0;
    fw_ident = '0;
    req = '0;
    boot(1);
    acc(0, 8'h2C, '1, 0, 33'h15A5AA5A5);
    fw(16'h0000, 32'h11112222);
    acc(0, 8'h2C, '1, 0, 33'h15A5AA5A5);
    fw(16'h0800, 32'h11112222);
    acc(0, 8'h2C, '1, 0, 33'h11111A5A5);
    fw(16'h0002, 32'h33334444);
    acc(0, 8'h2C, '1, 0, 33'h111114444);
    acc(0, 8'h34, '1, 0, 33'h100000040);
    acc(1, 8'h3C, 4'hE, '1, 33'h100000000);
    acc(0, 8'h3C, '1, 0, 33'h100000100);
    acc(1, 8'h3C, '1, 32'h5A, 33'h100000000);
    acc(0, 8'h3C, '1, 0, 33'h10000015A);
    acc(0, 8'h40, '1, 0, 33'h16C420001);
    aux_power_detect = 1;
    repeat (5) @(negedge clk);
    acc(0, 8'h40, '1, 0, 33'h1EC420001);
    acc(0, 8'h44, '1, 0, 33'h100000000);
    acc(0, 8'h48, '1, 0, 33'h000000000);
    boot(0);
    acc(0, 8'h2C, '1, 0, 33'h10A5A0C3C);
    acc(0, 8'h3C, '1, 0, 33'h100000100);
    complete_run;
  end
endmodule // test_pci_config_header_pm_capability
